/* File: hdl/dmach_defs.svh */
// offsets, field positions, control reset value and counter and link widths of the channel
`ifndef DMACH_DEFS_SVH
`define DMACH_DEFS_SVH
`define DMACH_OFS_SRC    12'h000
`define DMACH_OFS_DST    12'h004
`define DMACH_OFS_CNT    12'h008
`define DMACH_OFS_CTRL   12'h00C
`define DMACH_OFS_STAT   12'h010
`define DMACH_OFS_LINK   12'h014
`define DMACH_OFS_CMD    12'h018
`define DMACH_CNT_W      24
`define DMACH_LNK_W      2
`define DMACH_CTRL_RST   32'h2000_0000
`define DMACH_CTRL_RSTB  29
`define DMACH_CTRL_ERQ   0
`define DMACH_CTRL_CS    1
`define DMACH_CTRL_AA    2
`define DMACH_CTRL_EADR  3
`define DMACH_CTRL_D_REQ 4
`define DMACH_CTRL_SOURCE_INCREMENT_ENABLE  5
`define DMACH_CTRL_DESTINATION_INCREMENT_ENABLE  6
`define DMACH_CTRL_INT   7
`define DMACH_CTRL_SSZ   8
`define DMACH_CTRL_DSZ   10
`define DMACH_CTRL_SMOD  12
`define DMACH_CTRL_DMOD  16
`define DMACH_CTRL_LINKC 20
`define DMACH_CMD_START  0
`define DMACH_CMD_RESET  1
`define DMACH_ST_DONE    24
`define DMACH_ST_BSY     25
`define DMACH_ST_REQ     26
`define DMACH_ST_BED     28
`define DMACH_ST_BES     29
`define DMACH_ST_CE      30
`endif

/* File: hdl/dmach_pkg.sv */
// types shared by the channel files
package dmach_pkg;
  typedef enum logic [1:0] {
    DMACH_W32, DMACH_W8, DMACH_W16, DMACH_WBAD
  } dmach_width_t;
  typedef enum logic [1:0] {
    DMACH_LNK_OFF, DMACH_LNK_BOTH, DMACH_LNK_EACH, DMACH_LNK_END
  } dmach_link_t;
  typedef enum logic [1:0] {
    DMACH_IDLE, DMACH_RD, DMACH_WR
  } dmach_fsm_t;
  typedef struct packed {
    logic        req;
    logic        write;
    logic [31:0] addr;
    logic [1:0]  size;
    logic [31:0] wdata;
  } dmach_mreq_t;
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } dmach_mrsp_t;
endpackage : dmach_pkg

/* File: hdl/dmach_addr_step.sv */
// next address of one side: increment by width with optional modulo wrap
module dmach_addr_step
  import dmach_pkg::*;
(
  input  wire logic [31:0] addr,
  input  wire logic [1:0]  size,
  input  wire logic        step_en,
  input  wire logic [3:0]  modulo,
  output logic      [31:0] next_addr
);
  logic [31:0] inc;
  logic [31:0] keep_mask;
  always_comb begin
    unique case (dmach_width_t'(size))
      DMACH_W8:  inc = addr + 32'h0000_0001;
      DMACH_W16: inc = addr + 32'h0000_0002;
      default:   inc = addr + 32'h0000_0004;
    endcase
    // modulo n means a buffer of 2^(n+3) bytes
    keep_mask = (modulo == 4'h0) ? 32'h0000_0000
                : (32'hFFFF_FFFF << (5'(modulo) + 5'h03));
    if (!step_en) begin
      next_addr = addr;
    end else begin
      next_addr = (addr & keep_mask) | (inc & ~keep_mask);
    end
  end
endmodule : dmach_addr_step

/* File: hdl/dmach_channel.sv */
// one dma channel: apb registers, bus master and link requests
`include "dmach_defs.svh"
module dmach_channel
  import dmach_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    periph_req_pin,
  input  wire logic                    stop_mode,
  input  wire dmach_mrsp_t             mrsp,
  output dmach_mreq_t                  mreq,
  output logic                         irq,
  output logic                         link_req,
  output logic      [`DMACH_LNK_W-1:0] link_chan
);
  typedef struct packed {
    logic [31:0]             src;
    logic [31:0]             dst;
    logic [`DMACH_CNT_W-1:0] cnt;
    logic [31:0]             ctrl;
    logic [3:0]              lnk;
    logic                    done, bsy, req, bed, bes, ce;
    logic                    sw_go;
    dmach_fsm_t              fsm;
    logic [31:0]             data;
    dmach_mreq_t             mreq;
    logic [31:0]             prdata;
    logic                    pready, pslverr;
    logic                    irq, link_req;
    logic [`DMACH_LNK_W-1:0] link_chan;
    logic [1:0]              sync;
  } dmach_state_t;
  dmach_state_t r, next_r;
  logic [31:0] next_src, next_dst;
  logic        src_step, dst_step;
  logic [2:0]  sbytes, dbytes;
  logic        aa, cs, erq, auto_stop, cfg_bad, access, periph_req;
  logic        setup, mapped;
  dmach_link_t lmode;

  assign aa         = r.ctrl[`DMACH_CTRL_AA];
  assign cs         = r.ctrl[`DMACH_CTRL_CS];
  assign erq        = r.ctrl[`DMACH_CTRL_ERQ];
  assign auto_stop  = r.ctrl[`DMACH_CTRL_D_REQ];
  assign lmode      = dmach_link_t'(r.ctrl[`DMACH_CTRL_LINKC +: 2]);
  assign periph_req = r.sync[1];
  assign src_step = r.ctrl[`DMACH_CTRL_SOURCE_INCREMENT_ENABLE] | aa;
  assign dst_step = r.ctrl[`DMACH_CTRL_DESTINATION_INCREMENT_ENABLE] | aa;

  dmach_addr_step u_src_step (
    .addr      (r.src),
    .size      (r.ctrl[`DMACH_CTRL_SSZ +: 2]),
    .step_en   (src_step),
    .modulo    (r.ctrl[`DMACH_CTRL_SMOD +: 4]),
    .next_addr (next_src)
  );
  dmach_addr_step u_dst_step (
    .addr      (r.dst),
    .size      (r.ctrl[`DMACH_CTRL_DSZ +: 2]),
    .step_en   (dst_step),
    .modulo    (r.ctrl[`DMACH_CTRL_DMOD +: 4]),
    .next_addr (next_dst)
  );

  function automatic logic [2:0] width_bytes(input logic [1:0] sz);
    unique case (dmach_width_t'(sz))
      DMACH_W8:  width_bytes = 3'h1;
      DMACH_W16: width_bytes = 3'h2;
      default:   width_bytes = 3'h4;
    endcase
  endfunction : width_bytes

  assign sbytes = width_bytes(r.ctrl[`DMACH_CTRL_SSZ +: 2]);
  assign dbytes = width_bytes(r.ctrl[`DMACH_CTRL_DSZ +: 2]);
  // reserved width code or unequal widths are a configuration error
  assign cfg_bad = (r.ctrl[`DMACH_CTRL_SSZ +: 2] == 2'h3)
                 | (r.ctrl[`DMACH_CTRL_DSZ +: 2] == 2'h3)
                 | (sbytes != dbytes)
                 | (r.cnt[2:0] & (sbytes - 3'h1)) != 3'h0;
  assign access  = psel & penable & r.pready;
  // read data and error are registered at setup so they stand with pready
  assign setup   = psel & ~penable;
  assign mapped  = paddr inside {`DMACH_OFS_SRC, `DMACH_OFS_DST,
                                 `DMACH_OFS_CNT, `DMACH_OFS_CTRL,
                                 `DMACH_OFS_STAT, `DMACH_OFS_LINK,
                                 `DMACH_OFS_CMD};

  always_comb begin
    next_r          = r;
    next_r.pready   = setup;
    next_r.pslverr  = setup & ~mapped;
    next_r.link_req = 1'b0;
    next_r.sw_go    = 1'b0;
    next_r.irq      = r.ctrl[`DMACH_CTRL_INT] & r.done;
    next_r.sync     = {r.sync[0], periph_req_pin};
    // request pending reflects synchronised peripheral request
    // in stop mode only async-enabled requests are seen
    next_r.req = periph_req & (~stop_mode | r.ctrl[`DMACH_CTRL_EADR]);

    unique case (r.fsm)
      DMACH_IDLE: begin
        // start on software go or enabled request
        // peripheral paced when request enable is set
        if ((r.sw_go | (erq & r.req)) && r.cnt != '0 && !r.ce) begin
          if (cfg_bad) begin
            next_r.ce   = 1'b1;
            next_r.done = 1'b1;
            next_r.bsy  = 1'b0;
          end else begin
            next_r.bsy        = 1'b1;
            next_r.fsm        = DMACH_RD;
            next_r.mreq.req   = 1'b1;
            next_r.mreq.write = 1'b0;
            next_r.mreq.addr  = r.src;
            next_r.mreq.size  = r.ctrl[`DMACH_CTRL_SSZ +: 2];
          end
        end
      end
      DMACH_RD: begin
        if (mrsp.ack) begin
          next_r.mreq.req = 1'b0;
          if (mrsp.err) begin
            // source bus error stops the channel
            next_r.bes  = 1'b1;
            next_r.done = 1'b1;
            next_r.bsy  = 1'b0;
            next_r.fsm  = DMACH_IDLE;
          end else begin
            next_r.data        = mrsp.rdata;
            next_r.src         = next_src;
            next_r.fsm         = DMACH_WR;
            next_r.mreq.req    = 1'b1;
            next_r.mreq.write  = 1'b1;
            next_r.mreq.addr   = r.dst;
            next_r.mreq.size   = r.ctrl[`DMACH_CTRL_DSZ +: 2];
            next_r.mreq.wdata  = mrsp.rdata;
          end
        end
      end
      DMACH_WR: begin
        if (mrsp.ack) begin
          next_r.mreq.req = 1'b0;
          next_r.fsm      = DMACH_IDLE;
          if (mrsp.err) begin
            next_r.bed  = 1'b1;
            next_r.done = 1'b1;
            next_r.bsy  = 1'b0;
          end else begin
            next_r.dst = next_dst;
            next_r.cnt = r.cnt - `DMACH_CNT_W'(dbytes);
            // link after each cycle steal pair
            if (cs && (lmode == DMACH_LNK_EACH ||
                       lmode == DMACH_LNK_BOTH)) begin
              next_r.link_req  = 1'b1;
              next_r.link_chan = r.lnk[1:0];
            end
            if (r.cnt == `DMACH_CNT_W'(dbytes)) begin
              // completion sets done and clears busy
              next_r.done = 1'b1;
              next_r.bsy  = 1'b0;
              if (auto_stop) begin
                next_r.ctrl[`DMACH_CTRL_ERQ] = 1'b0;
              end
              if (lmode == DMACH_LNK_END) begin
                next_r.link_req  = 1'b1;
                next_r.link_chan = r.lnk[1:0];
              end else if (lmode == DMACH_LNK_BOTH) begin
                next_r.link_req  = 1'b1;
                next_r.link_chan = r.lnk[3:2];
              end
            end else if (!cs) begin
              // continuous mode keeps going until zero
              next_r.fsm        = DMACH_RD;
              next_r.mreq.req   = 1'b1;
              next_r.mreq.write = 1'b0;
              next_r.mreq.addr  = next_r.src;
              next_r.mreq.size  = r.ctrl[`DMACH_CTRL_SSZ +: 2];
            end else begin
              next_r.bsy = 1'b0;
            end
          end
        end
      end
      default: next_r.fsm = DMACH_IDLE;
    endcase

    if (setup && !pwrite) begin
      unique case (paddr)
        `DMACH_OFS_SRC:  next_r.prdata = r.src;
        `DMACH_OFS_DST:  next_r.prdata = r.dst;
        `DMACH_OFS_CTRL: next_r.prdata = r.ctrl;
        `DMACH_OFS_LINK: next_r.prdata = {28'h000_0000, r.lnk};
        `DMACH_OFS_CMD:  next_r.prdata = 32'h0000_0000;
        `DMACH_OFS_CNT, `DMACH_OFS_STAT: begin
          next_r.prdata = {8'h00, r.cnt};
          next_r.prdata[`DMACH_ST_DONE] = r.done;
          next_r.prdata[`DMACH_ST_BSY]  = r.bsy;
          next_r.prdata[`DMACH_ST_REQ]  = r.req;
          next_r.prdata[`DMACH_ST_BED]  = r.bed;
          next_r.prdata[`DMACH_ST_BES]  = r.bes;
          next_r.prdata[`DMACH_ST_CE]   = r.ce;
        end
        default: next_r.prdata = 32'h0000_0000;
      endcase
    end else if (access && pwrite) begin
      next_r.prdata = 32'h0000_0000;
      // address and length writes are ignored while busy to keep a block coherent; control and link writes always land
      unique case (paddr)
        `DMACH_OFS_SRC:  if (!r.bsy) next_r.src = pwdata;
        `DMACH_OFS_DST:  if (!r.bsy) next_r.dst = pwdata;
        `DMACH_OFS_CTRL: next_r.ctrl = pwdata;
        `DMACH_OFS_LINK: next_r.lnk = pwdata[3:0];
        `DMACH_OFS_CNT, `DMACH_OFS_STAT: begin
          // writing done clears done, bed, bes and ce; a fresh length loads the counter
          // a flag raised in this very cycle survives the clear
          if (pwdata[`DMACH_ST_DONE]) begin
            next_r.done = next_r.done & ~r.done;
            next_r.bed  = next_r.bed & ~r.bed;
            next_r.bes  = next_r.bes & ~r.bes;
            next_r.ce   = next_r.ce & ~r.ce;
          end else if (!r.bsy) begin
            // programmed length loads the byte counter
            next_r.cnt = pwdata[`DMACH_CNT_W-1:0];
          end
        end
        `DMACH_OFS_CMD: begin
          next_r.sw_go = pwdata[`DMACH_CMD_START];
          if (pwdata[`DMACH_CMD_RESET] && !r.bsy) begin
            next_r.src  = 32'h0000_0000;
            next_r.dst  = 32'h0000_0000;
            next_r.cnt  = '0;
            next_r.ctrl = `DMACH_CTRL_RST;
            next_r.lnk  = 4'h0;
            next_r.done = 1'b0;
            next_r.bed  = 1'b0;
            next_r.bes  = 1'b0;
            next_r.ce   = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r      <= '0;
      r.ctrl <= `DMACH_CTRL_RST;
      r.fsm  <= DMACH_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign prdata    = r.prdata;
  assign pready    = r.pready;
  assign pslverr   = r.pslverr;
  assign mreq      = r.mreq;
  assign irq       = r.irq;
  assign link_req  = r.link_req;
  assign link_chan = r.link_chan;
endmodule : dmach_channel

/* File: testbench/dmach_channel_monitor.sv */
// port checker for one dma channel
module dmach_channel_monitor
  import dmach_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire dmach_mreq_t mreq,
  input wire dmach_mrsp_t mrsp,
  input wire logic        link_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rd_q;
  logic        wr_ack;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign wr_ack = mreq.req && mreq.write && mrsp.ack;
  sequence rd_done;
    mreq.req && !mreq.write && mrsp.ack && !mrsp.err;
  endsequence
  sequence wr_next;
    ##[1:2] (mreq.req && mreq.write);
  endsequence
  // last read word, the write that follows must carry it unchanged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= '0;
    end else if (mreq.req && !mreq.write && mrsp.ack) begin
      rd_q <= mrsp.rdata;
    end
  end
  chk_apb_ready: assert property (
    psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready held too long");
  chk_err_ready: assert property (
    pslverr |-> pready)
    else $error("error without ready");
  chk_req_stable: assert property (
    mreq.req && !mrsp.ack |=> $stable(mreq))
    else $error("request changed before ack");
  chk_pair_order: assert property (
    rd_done |-> wr_next)
    else $error("read not followed by write");
  // continuous mode may go straight on to the next read, never a write
  chk_wr_release: assert property (
    wr_ack |=> !(mreq.req && mreq.write))
    else $error("write repeated after write ack");
  chk_wdata_copy: assert property (
    mreq.req && mreq.write |-> mreq.wdata == rd_q)
    else $error("write data differs from read");
  chk_err_halt: assert property (
    mreq.req && mrsp.ack && mrsp.err |=> !mreq.req [*2])
    else $error("transfer went on after bus error");
  chk_link_cause: assert property (
    link_req |-> $past(wr_ack) || $past(wr_ack, 2))
    else $error("link pulse without a write");
endmodule : dmach_channel_monitor

bind dmach_channel dmach_channel_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .mreq(mreq), .mrsp(mrsp),
  .link_req(link_req)
);

/* File: testbench/dmach_mem_model.sv */
// far-side memory: answers after a set wait, optional error on reads
module dmach_mem_model
  import dmach_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire dmach_mreq_t mreq,
  input  wire logic [3:0]  wait_cyc,
  input  wire logic        rd_err,
  output dmach_mrsp_t      mrsp,
  output logic [31:0]      rd_addr,
  output logic [31:0]      wr_addr,
  output logic [31:0]      wr_data,
  output int               wr_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mrsp <= '0;
      cnt <= '0;
      wr_cnt <= 0;
    end else if (mreq.req && !mrsp.ack && cnt >= wait_cyc) begin
      mrsp.ack <= 1'b1;
      mrsp.err <= rd_err && !mreq.write;
      mrsp.rdata <= {mreq.addr[15:0], ~mreq.addr[15:0]};
      cnt <= '0;
      if (mreq.write) begin
        wr_addr <= mreq.addr;
        wr_data <= mreq.wdata;
        wr_cnt <= wr_cnt + 1;
      end else begin
        rd_addr <= mreq.addr;
      end
    end else begin
      mrsp.ack <= 1'b0;
      mrsp.err <= 1'b0;
      // data bus released: never leave the last word standing
      mrsp.rdata <= ~mrsp.rdata;
      cnt <= mreq.req ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : dmach_mem_model

/* File: testbench/dmach_channel_tb.sv */
// self-checking bench for one dma channel with its memory model
`include "dmach_defs.svh"
module dmach_channel_tb
  import dmach_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        preq, irq, link_req, rd_err, e, stop;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_addr, wr_addr, wr_data, rv;
  logic [1:0]  link_chan, lchan;
  logic [3:0]  wait_cyc;
  dmach_mreq_t mreq;
  dmach_mrsp_t mrsp;
  int          n_mismatch = 0, n_compared = 0, wr_cnt, n_link = 0;
  dmach_channel uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph_req_pin(preq),
    .stop_mode(stop), .mrsp(mrsp), .mreq(mreq), .irq(irq),
    .link_req(link_req), .link_chan(link_chan)
  );
  dmach_mem_model u_mem (
    .pclk(pclk), .presetn(presetn), .mreq(mreq), .wait_cyc(wait_cyc),
    .rd_err(rd_err), .mrsp(mrsp), .rd_addr(rd_addr), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_cnt(wr_cnt)
  );
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    if (link_req === 1'b1) begin
      n_link++;
      lchan = link_chan;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // wait states are not counted here; only the watchdog ends a hang
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic prog(input logic [31:0] s, d, n, c);
    apb(1'b1, `DMACH_OFS_CNT, 32'h0100_0000);
    apb(1'b1, `DMACH_OFS_SRC, s);
    apb(1'b1, `DMACH_OFS_DST, d);
    apb(1'b1, `DMACH_OFS_CNT, n);
    apb(1'b1, `DMACH_OFS_CTRL, c);
  endtask : prog
  task automatic wait_done();
    for (int i = 0; i < 100; i++) begin
      apb(1'b0, `DMACH_OFS_STAT, '0);
      if (rv[`DMACH_ST_DONE] === 1'b1) break;
    end
  endtask : wait_done
  task automatic t_regs();
    apb(1'b0, `DMACH_OFS_CTRL, '0);
    check(rv, `DMACH_CTRL_RST);
    apb(1'b0, 12'h01C, '0);
    check({31'h0, e}, 32'h1);
    check(rv, 32'h0);
    // channel reset, then cycle steal and auto stop
    apb(1'b1, `DMACH_OFS_CTRL, 32'h0000_00FF);
    apb(1'b1, `DMACH_OFS_CMD, 32'h2);
    apb(1'b0, `DMACH_OFS_CTRL, '0);
    check(rv, `DMACH_CTRL_RST);
    apb(1'b1, `DMACH_OFS_CTRL, `DMACH_CTRL_RST | 32'h0000_0012);
  endtask : t_regs
  // continuous peripheral-driven block, link to channel 1 at the end
  task automatic t_burst();
    int l0;
    l0 = n_link;
    apb(1'b1, `DMACH_OFS_LINK, 32'h1);
    prog(32'h100, 32'h200, 32'h8, 32'h0030_00E1);
    preq <= 1'b1;
    repeat (4) @(posedge pclk);
    preq <= 1'b0;
    wait_done();
    check(rv & 32'h03FF_FFFF, 32'h0100_0000);
    check(32'(wr_cnt), 32'h2);
    check(rd_addr, 32'h104);
    check(wr_addr, 32'h204);
    check(wr_data, {16'h0104, 16'hFEFB});
    check({31'h0, irq}, 32'h1);
    check(32'(n_link - l0), 32'h1);
    check({30'h0, lchan}, 32'h1);
  endtask : t_burst
  // byte steals on a slow bus, 16 byte source ring, fixed destination
  task automatic t_steal();
    int l0, w0;
    l0 = n_link;
    w0 = wr_cnt;
    wait_cyc <= 4'h3;
    apb(1'b1, `DMACH_OFS_LINK, 32'h2);
    prog(32'h10E, 32'h300, 32'h4, 32'h0020_1522);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `DMACH_OFS_CMD, 32'h1);
      for (int j = 0; j < 60 && wr_cnt != w0 + i + 1; j++) @(posedge pclk);
      repeat (6) @(posedge pclk);
      check(32'(wr_cnt - w0), 32'(i + 1));
      apb(1'b0, `DMACH_OFS_STAT, '0);
      check({8'h0, rv[23:0]}, 32'(3 - i));
    end
    check(rd_addr, 32'h101);
    check(wr_addr, 32'h300);
    check(32'(n_link - l0), 32'h4);
    check({30'h0, lchan}, 32'h2);
    check({31'h0, irq}, 32'h0);
  endtask : t_steal
  // source bus error, then unequal widths; link off throughout
  task automatic t_err();
    int          l0;
    logic [31:0] ctl [2] = '{32'h0000_0002, 32'h0000_0102};
    logic [31:0] exp [2] = '{32'h2100_0000, 32'h4100_0000};
    l0 = n_link;
    for (int i = 0; i < 2; i++) begin
      rd_err <= (i == 0);
      prog(32'h400, 32'h500, 32'h4, ctl[i]);
      apb(1'b1, `DMACH_OFS_CMD, 32'h1);
      wait_done();
      check(rv & 32'h7300_0000, exp[i]);
    end
    rd_err <= 1'b0;
    check(32'(n_link - l0), 32'h0);
  endtask : t_err
  // 16-bit steals under stop mode, auto align, dual link and auto stop
  task automatic t_stop();
    int l0;
    l0 = n_link;
    apb(1'b1, `DMACH_OFS_LINK, 32'hD);
    prog(32'h600, 32'h700, 32'h4, 32'h0010_0A16);
    preq <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, `DMACH_OFS_STAT, '0);
    check(rv & 32'h04FF_FFFF, 32'h0400_0004);
    stop <= 1'b1;
    apb(1'b1, `DMACH_OFS_CTRL, 32'h0010_0A17);
    repeat (8) @(posedge pclk);
    apb(1'b0, `DMACH_OFS_STAT, '0);
    check(rv & 32'h04FF_FFFF, 32'h0000_0004);
    apb(1'b1, `DMACH_OFS_CTRL, 32'h0010_0A1F);
    wait_done();
    preq <= 1'b0;
    stop <= 1'b0;
    check(rv & 32'h03FF_FFFF, 32'h0100_0000);
    check(rd_addr, 32'h602);
    check(wr_addr, 32'h702);
    check(wr_data, {16'h0602, 16'hF9FD});
    check(32'(n_link - l0), 32'h2);
    check({30'h0, lchan}, 32'h3);
    apb(1'b0, `DMACH_OFS_CTRL, '0);
    check(rv, 32'h0010_0A1E);
  endtask : t_stop
  task automatic end_sim();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, preq, rd_err, stop} = '0;
    paddr = '0;
    pwdata = '0;
    wait_cyc = '0;
    // clock runs from time zero, before any programming
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_burst();
    t_steal();
    t_err();
    t_stop();
    end_sim();
  end
endmodule : dmach_channel_tb
